/* design/swgc_pkg.sv */
package swgc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h32c;

  // ----------------------------------------
  // field positions of the control word
  // ----------------------------------------
  localparam int FULL_RST_BIT   = 0;
  localparam int WARM_RST_BIT   = 1;
  localparam int HOLD_BIT       = 2;
  localparam int UNLOCK_BIT     = 3;
  localparam int PB_UNLOCK_BIT  = 4;
  localparam int LD_DIS_BIT     = 5;
  localparam int EE_DIS_BIT     = 6;
  localparam int ORDER_BIT      = 7;
  localparam int PEER_DIS_BIT   = 8;
  localparam int CT_DIS_BIT     = 14;
  localparam int LOCK_BYP_BIT   = 15;
  localparam int WAKE_DIR_BIT   = 16;
  localparam int AUX_EN_BIT     = 17;
  localparam int BCAST_DIS_BIT  = 18;

  // bits that hold state and read back; all others read as zero
  localparam logic [31:0] READ_MASK = 32'h0007_c1fc;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic FIELD_RST    = 1'b0;
  localparam logic WAKE_DIR_POR = 1'b0;
  localparam logic AUX_EN_RST   = 1'b0;

  // ----------------------------------------
  // state of the block
  // ----------------------------------------
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        por_done;
    logic        full_req;
    logic        warm_req;
    logic        hold;
    logic        unlock;
    logic        pb_unlock;
    logic        ld_dis;
    logic        ee_dis;
    logic        order;
    logic        peer_dis;
    logic        ct_dis;
    logic        lock_byp;
    logic        wake_dir;
    logic        aux_en;
    logic        bcast_dis;
  } swgc_state_t;

endpackage : swgc_pkg

/* design/swgc_ctrl.sv */
// Our own choice: the APB slave port.
`timescale 1ns/10ps
// Function
// - full reset trigger pulses; reads zero
// - warm reset trigger pulses; reads zero
// - reset hold keeps switch logic in reset
// - eeprom error sets reset hold
// - lockable fields written only when unlocked
// - unlock forced high during reset operation
// - power budget data writable only when unlocked
// - link down warm reset can be disabled
// - warm reset may skip eeprom reload
// - ordering override forces strict ordering
// - peer traffic disable makes unsupported requests
// - cut through disable selects store forward
// - lock bypass treats locked requests normally
// - wake direction selects wake pin direction
// - wake direction cleared at aux power on
// - aux enable loads inverse of disable pin
// - aux enable permits aux power use
// - broadcast discard drops upstream vendor broadcasts
module swgc_ctrl (
  // clock and reset; presetn is the aux power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // reset sequencer and eeprom loader
  input  wire logic        full_rst_event,
  input  wire logic        reset_busy,
  input  wire logic        reset_hold_strap,
  input  wire logic        eeprom_error,
  input  wire logic        dl_down_event,
  input  wire logic        aux_power_disable_pin,
  output logic             full_reset_trigger,
  output logic             warm_reset_trigger,
  output logic             reset_hold,
  output logic             warm_reset_eeprom_reload_disable,
  // routing core
  output logic             lockable_write_enable,
  output logic             power_budget_unlock,
  output logic             ordering_override,
  output logic             peer_traffic_disable,
  output logic             cut_through_disable,
  output logic             lock_side_effect_bypass,
  output logic             broadcast_discard,
  // power and wake
  output logic             wake_pin_direction,
  output logic             aux_power_enable
);

  swgc_pkg::swgc_state_t s_reg;
  swgc_pkg::swgc_state_t s_next;

  logic        setup;
  logic        hit;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        lane0_wr;
  logic        lane1_wr;
  logic        lane2_wr;

  assign setup  = psel & ~penable;
  assign hit    = (paddr == swgc_pkg::CTRL_OFS);
  assign wr_hit = psel & penable & s_reg.pready & pwrite & hit;
  assign lane0_wr = wr_hit & pstrb[0];
  assign lane1_wr = wr_hit & pstrb[1];
  assign lane2_wr = wr_hit & pstrb[2];

  // ----------------------------------------
  // read view
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0;
    // trigger bits and reserved bits stay zero
    rd_val[swgc_pkg::HOLD_BIT]      = s_reg.hold;
    rd_val[swgc_pkg::UNLOCK_BIT]    = s_reg.unlock;
    rd_val[swgc_pkg::PB_UNLOCK_BIT] = s_reg.pb_unlock;
    rd_val[swgc_pkg::LD_DIS_BIT]    = s_reg.ld_dis;
    rd_val[swgc_pkg::EE_DIS_BIT]    = s_reg.ee_dis;
    rd_val[swgc_pkg::ORDER_BIT]     = s_reg.order;
    rd_val[swgc_pkg::PEER_DIS_BIT]  = s_reg.peer_dis;
    rd_val[swgc_pkg::CT_DIS_BIT]    = s_reg.ct_dis;
    rd_val[swgc_pkg::LOCK_BYP_BIT]  = s_reg.lock_byp;
    rd_val[swgc_pkg::WAKE_DIR_BIT]  = s_reg.wake_dir;
    rd_val[swgc_pkg::AUX_EN_BIT]    = s_reg.aux_en;
    rd_val[swgc_pkg::BCAST_DIS_BIT] = s_reg.bcast_dis;
    rd_val = rd_val & swgc_pkg::READ_MASK;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    // answer is prepared in setup so pready comes from a flop
    s_next.pready  = setup;
    s_next.pslverr = setup & ~hit;
    s_next.prdata  = (setup & hit) ? rd_val : 32'h0;
    s_next.full_req = 1'b0;
    s_next.warm_req = dl_down_event & ~s_reg.ld_dis;

    if (wr_hit) begin
      if (pstrb[0]) begin
        s_next.full_req = pwdata[swgc_pkg::FULL_RST_BIT];
        if (pwdata[swgc_pkg::WARM_RST_BIT]) begin
          s_next.warm_req = 1'b1;
        end
        s_next.hold   = pwdata[swgc_pkg::HOLD_BIT];
        s_next.unlock = pwdata[swgc_pkg::UNLOCK_BIT];
        if (s_reg.unlock) begin
          s_next.pb_unlock = pwdata[swgc_pkg::PB_UNLOCK_BIT];
        end
        s_next.ld_dis = pwdata[swgc_pkg::LD_DIS_BIT];
        s_next.ee_dis = pwdata[swgc_pkg::EE_DIS_BIT];
        s_next.order  = pwdata[swgc_pkg::ORDER_BIT];
      end
      if (pstrb[1]) begin
        s_next.peer_dis = pwdata[swgc_pkg::PEER_DIS_BIT];
        s_next.ct_dis   = pwdata[swgc_pkg::CT_DIS_BIT];
        s_next.lock_byp = pwdata[swgc_pkg::LOCK_BYP_BIT];
      end
      if (pstrb[2]) begin
        s_next.wake_dir  = pwdata[swgc_pkg::WAKE_DIR_BIT];
        s_next.aux_en    = pwdata[swgc_pkg::AUX_EN_BIT];
        s_next.bcast_dis = pwdata[swgc_pkg::BCAST_DIS_BIT];
      end
    end

    // fundamental reset loads hold from the strap, clears the other sticky fields, spares wake and aux
    if (full_rst_event) begin
      s_next.hold      = reset_hold_strap;
      s_next.unlock    = swgc_pkg::FIELD_RST;
      s_next.pb_unlock = swgc_pkg::FIELD_RST;
      s_next.ld_dis    = swgc_pkg::FIELD_RST;
      s_next.ee_dis    = swgc_pkg::FIELD_RST;
      s_next.order     = swgc_pkg::FIELD_RST;
      s_next.peer_dis  = swgc_pkg::FIELD_RST;
      s_next.ct_dis    = swgc_pkg::FIELD_RST;
      s_next.lock_byp  = swgc_pkg::FIELD_RST;
      s_next.bcast_dis = swgc_pkg::FIELD_RST;
    end

    // pin is caught by a clocked load right after aux power-on
    if (!s_reg.por_done) begin
      s_next.por_done = 1'b1;
      s_next.aux_en   = ~aux_power_disable_pin;
    end

    // hardware sets win over software clears
    if (eeprom_error) begin
      s_next.hold = 1'b1;
    end
    if (reset_busy) begin
      s_next.unlock = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.hold      <= swgc_pkg::FIELD_RST;
      s_reg.wake_dir  <= swgc_pkg::WAKE_DIR_POR;
      s_reg.aux_en    <= swgc_pkg::AUX_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready                           = s_reg.pready;
  assign pslverr                          = s_reg.pslverr;
  assign prdata                           = s_reg.prdata;
  assign full_reset_trigger               = s_reg.full_req;
  assign warm_reset_trigger               = s_reg.warm_req;
  assign reset_hold                       = s_reg.hold;
  assign warm_reset_eeprom_reload_disable = s_reg.ee_dis;
  assign lockable_write_enable            = s_reg.unlock;
  assign power_budget_unlock              = s_reg.pb_unlock;
  assign ordering_override                = s_reg.order;
  assign peer_traffic_disable             = s_reg.peer_dis;
  assign cut_through_disable              = s_reg.ct_dis;
  assign lock_side_effect_bypass          = s_reg.lock_byp;
  assign broadcast_discard                = s_reg.bcast_dis;
  assign wake_pin_direction               = s_reg.wake_dir;
  assign aux_power_enable                 = s_reg.aux_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_pulse: assert property (
    wr_hit && pstrb[0] && pwdata[0] |=> full_reset_trigger ##1 !full_reset_trigger)
    else $error("full reset trigger not a single pulse");

  a_trig_read: assert property (
    pready && !pslverr |-> prdata[1:0] == 2'h0)
    else $error("trigger bits read nonzero");

  a_warm_pulse: assert property (
    wr_hit && pstrb[0] && pwdata[1] |=> warm_reset_trigger)
    else $error("warm reset trigger missing");

  a_hold_fall: assert property (
    $fell(reset_hold) |-> $past(wr_hit) || $past(full_rst_event))
    else $error("reset hold cleared without cause");

  a_hold_error: assert property (
    eeprom_error |=> reset_hold)
    else $error("eeprom error did not set reset hold");

  a_lock_keep: assert property (
    wr_hit && !lockable_write_enable && !full_rst_event |=> $stable(power_budget_unlock))
    else $error("locked field changed");

  a_unlock_busy: assert property (
    reset_busy |=> lockable_write_enable)
    else $error("unlock not forced during reset");

  a_link_down: assert property (
    dl_down_event && s_reg.ld_dis && !wr_hit |=> !warm_reset_trigger)
    else $error("link down warm reset not suppressed");

  a_fr_keep: assert property (
    full_rst_event && !wr_hit && s_reg.por_done
      |=> $stable(wake_pin_direction) && $stable(aux_power_enable))
    else $error("wake or aux changed by fundamental reset");

  a_aux_load: assert property (
    $rose(s_reg.por_done) |-> aux_power_enable == !$past(aux_power_disable_pin))
    else $error("aux enable not loaded from pin");

  a_rsvd_zero: assert property (
    pready |-> (prdata & ~swgc_pkg::READ_MASK) == 32'h0)
    else $error("reserved bits read nonzero");

  // ----------------------------------------
  // field write checks
  // ----------------------------------------
  // a fundamental reset or hardware set in the same cycle outranks a write,
  // so those cycles are left out of the antecedents
  a_hold_write: assert property (
    lane0_wr && !full_rst_event && !eeprom_error
      |=> reset_hold == $past(pwdata[swgc_pkg::HOLD_BIT]))
    else $error("reset hold not written");

  a_hold_strap: assert property (
    full_rst_event && !eeprom_error
      |=> reset_hold == $past(reset_hold_strap))
    else $error("reset hold not loaded from strap");

  a_unlock_write: assert property (
    lane0_wr && !full_rst_event && !reset_busy
      |=> lockable_write_enable == $past(pwdata[swgc_pkg::UNLOCK_BIT]))
    else $error("unlock bit not written");

  a_unlock_clear: assert property (
    full_rst_event && !reset_busy
      |=> !lockable_write_enable)
    else $error("unlock not cleared by fundamental reset");

  a_pb_write: assert property (
    lane0_wr && lockable_write_enable && !full_rst_event
      |=> power_budget_unlock == $past(pwdata[swgc_pkg::PB_UNLOCK_BIT]))
    else $error("power budget unlock not written while unlocked");

  a_ee_write: assert property (
    lane0_wr && !full_rst_event
      |=> warm_reset_eeprom_reload_disable == $past(pwdata[swgc_pkg::EE_DIS_BIT]))
    else $error("eeprom reload disable not written");

  a_order_write: assert property (
    lane0_wr && !full_rst_event
      |=> ordering_override == $past(pwdata[swgc_pkg::ORDER_BIT]))
    else $error("ordering override not written");

  a_peer_write: assert property (
    lane1_wr && !full_rst_event
      |=> peer_traffic_disable == $past(pwdata[swgc_pkg::PEER_DIS_BIT]))
    else $error("peer traffic disable not written");

  a_ct_write: assert property (
    lane1_wr && !full_rst_event
      |=> cut_through_disable == $past(pwdata[swgc_pkg::CT_DIS_BIT]))
    else $error("cut through disable not written");

  a_byp_write: assert property (
    lane1_wr && !full_rst_event
      |=> lock_side_effect_bypass == $past(pwdata[swgc_pkg::LOCK_BYP_BIT]))
    else $error("lock bypass not written");

  a_wake_write: assert property (
    lane2_wr
      |=> wake_pin_direction == $past(pwdata[swgc_pkg::WAKE_DIR_BIT]))
    else $error("wake direction not written");

  a_wake_keep: assert property (
    !lane2_wr
      |=> $stable(wake_pin_direction))
    else $error("wake direction changed without a write");

  a_aux_keep: assert property (
    s_reg.por_done && !lane2_wr
      |=> $stable(aux_power_enable))
    else $error("aux enable changed without a write");

  a_aux_write: assert property (
    lane2_wr && s_reg.por_done
      |=> aux_power_enable == $past(pwdata[swgc_pkg::AUX_EN_BIT]))
    else $error("aux enable not written");

  a_bcast_write: assert property (
    lane2_wr && !full_rst_event
      |=> broadcast_discard == $past(pwdata[swgc_pkg::BCAST_DIS_BIT]))
    else $error("broadcast discard not written");

  a_full_quiet: assert property (
    !(lane0_wr && pwdata[swgc_pkg::FULL_RST_BIT])
      |=> !full_reset_trigger)
    else $error("full reset trigger without a write of one");

  a_warm_cause: assert property (
    !(lane0_wr && pwdata[swgc_pkg::WARM_RST_BIT]) && !(dl_down_event && !s_reg.ld_dis)
      |=> !warm_reset_trigger)
    else $error("warm reset trigger without a cause");

  a_link_warm: assert property (
    dl_down_event && !s_reg.ld_dis
      |=> warm_reset_trigger)
    else $error("link down warm reset missing");

  a_fr_clear: assert property (
    full_rst_event
      |=> !power_budget_unlock && !warm_reset_eeprom_reload_disable
        && !ordering_override && !peer_traffic_disable && !cut_through_disable
        && !lock_side_effect_bypass && !broadcast_discard)
    else $error("sticky field kept through fundamental reset");

  // ----------------------------------------
  // apb answer checks
  // ----------------------------------------
  a_ready_once: assert property (
    setup |=> pready)
    else $error("no answer after setup");

  a_ready_quiet: assert property (
    !setup |=> !pready)
    else $error("answer without setup");

  a_unmapped_err: assert property (
    setup && !hit
      |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  c_write: cover property (wr_hit ##1 pready);
  c_unmapped: cover property (pready && pslverr);
  c_err_hold: cover property (eeprom_error ##1 reset_hold);
  c_lock_write: cover property (lane0_wr && lockable_write_enable);
  c_link_warm: cover property (dl_down_event && !s_reg.ld_dis ##1 warm_reset_trigger);

endmodule : swgc_ctrl

/* tb/swgc_ctrl_tb_top.sv */
`timescale 1ns/10ps
module swgc_ctrl_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m, rd;
  logic [3:0]  pstrb;
  logic        fev, busy, strap, eerr, dld, apin;
  logic        frt, wrt, hold, eed, unl, pbu, ordo, peer, ctd, lsb, bcd, wdir, aux;
  integer      seed, error_cnt, n_checks, i;
  // bit 5 has no port of its own; it is judged through read-back and triggers
  wire  [31:0] outs = {13'h0, bcd, aux, wdir, lsb, ctd, 5'h0, peer, ordo, eed, 1'b0,
                       pbu, unl, hold, 2'h0};

  swgc_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .full_rst_event(fev), .reset_busy(busy), .reset_hold_strap(strap),
    .eeprom_error(eerr), .dl_down_event(dld), .aux_power_disable_pin(apin),
    .full_reset_trigger(frt), .warm_reset_trigger(wrt), .reset_hold(hold),
    .warm_reset_eeprom_reload_disable(eed), .lockable_write_enable(unl),
    .power_budget_unlock(pbu), .ordering_override(ordo), .peer_traffic_disable(peer),
    .cut_through_disable(ctd), .lock_side_effect_bypass(lsb), .broadcast_discard(bcd),
    .wake_pin_direction(wdir), .aux_power_enable(aux));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------
  // checking and expectation
  // ----------------------------------------
  task stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // power budget unlock only moves while the unlock bit already stands
  function automatic logic [31:0] nxt(input logic [31:0] c, d, input logic [3:0] s);
    logic [31:0] k;
    k = 32'h0;
    if (s[0]) k[7:0] = c[3] ? 8'hfc : 8'hec;
    if (s[1]) k[15:8] = 8'hc1;
    if (s[2]) k[23:16] = 8'h07;
    return (c & ~k) | (d & k);
  endfunction : nxt

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int j;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'h1;
    for (j = 0; j < 20; j++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (j == 20) begin
      // a lost answer counts as a mismatch and ends the run
      error_cnt = error_cnt + 1;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb

  task rdchk;
    apb(1'b0, swgc_pkg::CTRL_OFS, 32'h0, 4'h0);
    chk("read data", rd, m & swgc_pkg::READ_MASK);
    chk("read error", 32'(err), 32'h0);
  endtask : rdchk

  task wr(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, swgc_pkg::CTRL_OFS, d, s);
    m = nxt(m, d, s);
    #1;
    chk("full trigger", 32'(frt), 32'(s[0] & d[0]));
    chk("warm trigger", 32'(wrt), 32'(s[0] & d[1]));
    chk("lane0", outs & 32'hdc, m & 32'hdc);
    chk("lane1", outs & 32'hc100, m & 32'hc100);
    chk("lane2", outs & 32'h7_0000, m & 32'h7_0000);
    @(posedge pclk);
    #1;
    chk("trigger end", 32'({frt, wrt}), 32'h0);
    rdchk();
  endtask : wr

  // one-cycle pulse on {full reset, link down, eeprom error, reset busy}
  task side(input logic [3:0] v);
    @(posedge pclk);
    {fev, dld, eerr, busy} <= v;
    @(posedge pclk);
    {fev, dld, eerr, busy} <= 4'h0;
    #1;
  endtask : side

  task rst(input logic pin);
    @(posedge pclk);
    apin <= pin;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    m = {14'h0, ~pin, 17'h0};
    chk("after reset", outs, m);
  endtask : rst

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hcb93;
    error_cnt = 0;
    n_checks = 0;
    {presetn, psel, penable, pwrite, fev, busy, strap, eerr, dld} = 9'h0;
    apin = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    rst(1'b1);
    rdchk();
    wr(32'h3, 4'h1);
    wr(32'h10, 4'h1);
    wr(32'h18, 4'h1);
    wr(32'h18, 4'h1);
    for (i = 0; i < 40; i++) wr($random(seed), 4'($random(seed)));
    wr(32'h0, 4'h1);
    side(4'h4);
    chk("link down", 32'(wrt), 32'h1);
    wr(32'h20, 4'h1);
    side(4'h4);
    chk("link down off", 32'(wrt), 32'h0);
    wr(32'h0, 4'h1);
    side(4'h2);
    m[2] = 1'b1;
    chk("eeprom error", outs, m & 32'h0007_c1dc);
    side(4'h1);
    m[3] = 1'b1;
    chk("reset busy", outs, m & 32'h0007_c1dc);
    wr(32'h0007_c1ec, 4'h7);
    strap <= 1'h1;
    side(4'h8);
    m = (m & 32'h0003_0000) | 32'h4;
    chk("full reset", outs, m & 32'h0007_c1dc);
    rdchk();
    apb(1'b1, 12'h330, 32'hffff_ffff, 4'hf);
    chk("unmapped write", 32'(err), 32'h1);
    apb(1'b0, 12'h330, 32'h0, 4'h0);
    chk("unmapped read", {rd[30:0], err}, 32'h1);
    rdchk();
    rst(1'b0);
    stop_test();
  end
endmodule : swgc_ctrl_tb_top
